//--- imp_portal.sv
// indirect extended-register portal on the management register interface
// assumes one-cycle read/write strobes, never both in the same cycle;
// basicControl carries the live value of standard register 0
//
// How it works
// - Portal spans 32 device addresses of 65536 sixteen-bit registers each.
// - Control bits 15:14 pick the mode; 00 makes data register an address.
// - Mode 01 transfers data and keeps the held address.
// - Mode 10 bumps the held address after every read and write.
// - Mode 11 bumps the held address after writes only.
// - Control bits 4:0 choose the targeted device address.
// - In mode 00 data register writes load, reads return, the address.
// - Nonzero modes access the register at current device and address.
// - Burst reads in mode 10 return consecutive registers.
// - Link-up time register reachable only while basic control is 0x2100.
`timescale 1ns/1ps
module imp_portal (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWData,
  input wire logic [15:0] basicControl,
  output logic regHit,
  output logic [15:0] regRData,
  output logic regRValid,
  output logic [2:0] linkUpTime
);

  ////////////////////////////////////////////////////////////////////////////
  // decode helpers

  // true when an access in this mode moves the held address on
  function automatic logic bumps(input logic [1:0] mode, input logic wr,
                                 input logic rd);
    begin
      case (mode)
        imp_pkg::OP_INC_RW: bumps = wr || rd;
        imp_pkg::OP_INC_W: bumps = wr;
        default: bumps = 1'b0;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state

  imp_pkg::imp_portal_state_t st;
  imp_pkg::imp_portal_state_t next_st;
  logic [1:0] opMode;
  logic [4:0] devSel;
  logic hitCtrl;
  logic hitData;
  logic extWrite;
  logic [15:0] extRdData;

  assign opMode = st.ctrl[imp_pkg::MODE_HI:imp_pkg::MODE_LO];
  assign devSel = st.ctrl[imp_pkg::DEV_HI:imp_pkg::DEV_LO];
  assign hitCtrl = (regAddr == imp_pkg::OFF_CTRL);
  assign hitData = (regAddr == imp_pkg::OFF_DATA);
  assign regHit = hitCtrl || hitData;
  // data writes go to the indirect register in any nonzero mode
  assign extWrite = regWrite && hitData &&
                    (opMode != imp_pkg::OP_ADDR);

  ////////////////////////////////////////////////////////////////////////////
  // indirect register space

  imp_ext_bank imp_ext_bank_inst (
    .clk(clk),
    .rst(rst),
    .devAddr(devSel),
    .regIndex(st.addrHold),
    .wrEn(extWrite),
    .wrData(regWData),
    .basicControl(basicControl),
    .rdData(extRdData),
    .linkUpTime(linkUpTime)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb
  begin
    next_st = st;
    next_st.rdValid = 1'b0;
    if (regWrite && hitCtrl)
    begin
      // reserved bits 13:5 are plain storage
      next_st.ctrl = regWData;
    end
    if (regWrite && hitData && (opMode == imp_pkg::OP_ADDR))
    begin
      next_st.addrHold = regWData;
    end
    if (regRead)
    begin
      next_st.rdValid = 1'b1;
      next_st.rdData = 16'h0000;
      if (hitCtrl)
      begin
        next_st.rdData = st.ctrl;
      end
      else if (hitData)
      begin
        if (opMode == imp_pkg::OP_ADDR)
        begin
          next_st.rdData = st.addrHold;
        end
        else
        begin
          next_st.rdData = extRdData;
        end
      end
    end
    // the address advances after the transfer, wrapping at 16 bits
    if (hitData && bumps(opMode, regWrite, regRead))
    begin
      next_st.addrHold = st.addrHold + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registers

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st.ctrl <= imp_pkg::CTRL_RESET;
      st.addrHold <= imp_pkg::DATA_RESET;
      st.rdData <= 16'h0000;
      st.rdValid <= 1'b0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign regRData = st.rdData;
  assign regRValid = st.rdValid;

endmodule

//--- imp_pkg.sv
// constants and state types for the indirect extended-register portal
// assumes a 16-bit management register interface with 5-bit addresses
package imp_pkg;

  // directly addressed portal registers
  localparam logic [4:0] OFF_CTRL = 5'h0d;
  localparam logic [4:0] OFF_DATA = 5'h0e;
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  // control register fields
  localparam int MODE_HI = 15;
  localparam int MODE_LO = 14;
  localparam int DEV_HI = 4;
  localparam int DEV_LO = 0;

  // operation modes
  localparam logic [1:0] OP_ADDR = 2'h0;
  localparam logic [1:0] OP_DATA = 2'h1;
  localparam logic [1:0] OP_INC_RW = 2'h2;
  localparam logic [1:0] OP_INC_W = 2'h3;

  // indirect space size
  localparam int DEV_COUNT = 32;
  localparam int REGS_PER_DEV = 65536;
  localparam int WORD_W = 16;

  // link-up time control register, device 1 register 0x5a
  localparam logic [4:0] LUT_DEV = 5'h01;
  localparam logic [15:0] LUT_REG = 16'h005a;
  localparam int LUT_HI = 3;
  localparam int LUT_LO = 1;
  localparam logic [2:0] LUT_RESET = 3'h4;
  localparam logic [2:0] LUT_FAST = 3'h3;
  localparam int RSV_HI = 8;
  localparam int RSV_LO = 4;
  localparam logic [4:0] RSV_RESET = 5'h10;
  localparam int BIT0 = 0;
  localparam logic BIT0_RESET = 1'b0;

  // basic control value that opens the link-up time register
  localparam logic [15:0] FORCED_100 = 16'h2100;

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] addrHold;
    logic [15:0] rdData;
    logic rdValid;
  } imp_portal_state_t;

  typedef struct packed {
    logic [2:0] linkUpTime;
    logic [4:0] rsvField;
    logic bit0;
  } imp_ext_state_t;

endpackage

//--- imp_ext_bank.sv
// extended register bank behind the portal: link-up time control only
// assumes the portal gives a one-cycle write strobe and reads combinationally
`timescale 1ns/1ps
module imp_ext_bank (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] devAddr,
  input wire logic [15:0] regIndex,
  input wire logic wrEn,
  input wire logic [15:0] wrData,
  input wire logic [15:0] basicControl,
  output logic [15:0] rdData,
  output logic [2:0] linkUpTime
);

  imp_pkg::imp_ext_state_t st;
  imp_pkg::imp_ext_state_t next_st;
  logic hitLut;
  logic lutOpen;

  assign hitLut = (devAddr == imp_pkg::LUT_DEV) &&
                  (regIndex == imp_pkg::LUT_REG);
  // register only reachable with autonegotiation off and 100M forced
  assign lutOpen = (basicControl == imp_pkg::FORCED_100);

  always_comb
  begin
    next_st = st;
    rdData = 16'h0000;
    if (hitLut && lutOpen)
    begin
      rdData[imp_pkg::LUT_HI:imp_pkg::LUT_LO] = st.linkUpTime;
      rdData[imp_pkg::RSV_HI:imp_pkg::RSV_LO] = st.rsvField;
      rdData[imp_pkg::BIT0] = st.bit0;
      if (wrEn)
      begin
        // reserved codes are stored as written; 011 shortens link-up
        next_st.linkUpTime = wrData[imp_pkg::LUT_HI:imp_pkg::LUT_LO];
        next_st.rsvField = wrData[imp_pkg::RSV_HI:imp_pkg::RSV_LO];
        next_st.bit0 = wrData[imp_pkg::BIT0];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      st.linkUpTime <= imp_pkg::LUT_RESET;
      st.rsvField <= imp_pkg::RSV_RESET;
      st.bit0 <= imp_pkg::BIT0_RESET;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign linkUpTime = st.linkUpTime;

endmodule

//--- imp_chk.sv
// checker on the portal's register-bus ports
// assumes one clock domain and the synchronous active-high reset
`timescale 1ns/1ps
module imp_chk (
  input wire logic clk,
  input wire logic rst,
  input wire logic [4:0] regAddr,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [15:0] regWData,
  input wire logic [15:0] basicControl,
  input wire logic regHit,
  input wire logic [15:0] regRData,
  input wire logic regRValid,
  input wire logic [2:0] linkUpTime
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  chk_read_answer: assert property (regRead |=> regRValid)
    else $error("read not answered");
  chk_valid_cause: assert property (!regRead |=> !regRValid)
    else $error("answer without read");
  chk_hit_decode: assert property (regHit ==
    (regAddr == imp_pkg::OFF_CTRL || regAddr == imp_pkg::OFF_DATA))
    else $error("hit decode wrong");
  chk_lut_reset: assert property ($fell(rst) |->
    linkUpTime == imp_pkg::LUT_RESET)
    else $error("link-up time reset wrong");
  chk_lut_idle: assert property (!regWrite |=> $stable(linkUpTime))
    else $error("link-up time moved");
  chk_lut_gated: assert property (regWrite &&
    basicControl != imp_pkg::FORCED_100 |=> $stable(linkUpTime))
    else $error("gated write landed");
  chk_unmapped_zero: assert property (regRead && !regHit |=>
    regRData == 16'h0000)
    else $error("unmapped read not zero");
  chk_rdata_hold: assert property (!regRead |=> $stable(regRData))
    else $error("read data moved");
  cover property (regRead && regAddr == imp_pkg::OFF_DATA);
  cover property (regWrite && basicControl != imp_pkg::FORCED_100);
  cover property (regRValid && regRData != 16'h0000);
endmodule

//--- imp_host.sv
// management host model: one-cycle strobes launched at falling edges
// assumes the portal answers a read one cycle after its strobe edge
`timescale 1ns/1ps
module imp_host (
  input wire logic clk,
  input wire logic [15:0] regRData,
  input wire logic regRValid,
  output logic [4:0] regAddr,
  output logic regWrite,
  output logic regRead,
  output logic [15:0] regWData
);
  initial
  begin
    regAddr = 5'h00;
    regWrite = 1'b0;
    regRead = 1'b0;
    regWData = 16'h0000;
  end
  // write steps in caller order; data line inverted once released
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regWData = d;
    regWrite = 1'b1;
    @(negedge clk);
    regWrite = 1'b0;
    regWData = ~d;
  endtask
  // answer taken while the one-cycle valid stands
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk);
    regAddr = a;
    regRead = 1'b1;
    @(negedge clk);
    regRead = 1'b0;
    d = regRValid ? regRData : 16'hxxxx;
  endtask
endmodule

//--- indirect_mmd_register_portal_tb.sv
// testbench for the indirect register portal
// assumes imp_portal, imp_host and imp_chk are compiled before it
`timescale 1ns/1ps
module indirect_mmd_register_portal_tb;
  logic clk, rst, regWrite, regRead, regHit, regRValid;
  logic [4:0] regAddr;
  logic [15:0] regWData, basicControl, regRData, got;
  logic [2:0] linkUpTime;
  int errors = 0;
  int num_checks = 0;
  imp_portal imp_portal_inst (.clk, .rst, .regAddr, .regWrite, .regRead,
    .regWData, .basicControl, .regHit, .regRData, .regRValid, .linkUpTime);
  imp_host imp_host_inst (.clk, .regRData, .regRValid, .regAddr,
    .regWrite, .regRead, .regWData);
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [15:0] e,
                     input logic [15:0] s);
    num_checks++;
    if (s !== e)
    begin
      errors++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task automatic r(input logic [4:0] a, input logic [15:0] e);
    imp_host_inst.rd(a, got);
    cmp("read", e, got);
  endtask
  task automatic w(input logic [4:0] a, input logic [15:0] d);
    imp_host_inst.wr(a, d);
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial
  begin
    #4000;
    errors++;
    wrap_up;
  end
  initial
  begin
    rst = 1'b1;
    basicControl = 16'h2100;
    repeat (12) @(negedge clk);
    rst = 1'b0;
    r(5'h0d, 16'h0000);
    r(5'h0e, 16'h0000);
    w(5'h0d, 16'h0001);
    w(5'h0e, 16'h005a);
    r(5'h0e, 16'h005a);
    w(5'h0d, 16'h4001);
    w(5'h0e, 16'h0006);
    cmp("lut", 16'h0003, {13'h0000, linkUpTime});
    r(5'h0e, 16'h0006);
    r(5'h0d, 16'h4001);
    w(5'h0d, 16'h8001);
    r(5'h0e, 16'h0006);
    r(5'h0e, 16'h0000);
    w(5'h0e, 16'h0000);
    w(5'h0d, 16'h0001);
    r(5'h0e, 16'h005d);
    w(5'h0e, 16'h005a);
    w(5'h0d, 16'hc001);
    r(5'h0e, 16'h0006);
    w(5'h0e, 16'h0008);
    cmp("lut", 16'h0004, {13'h0000, linkUpTime});
    w(5'h0d, 16'h0001);
    r(5'h0e, 16'h005b);
    w(5'h0e, 16'h005a);
    w(5'h0d, 16'h4002);
    w(5'h0e, 16'h000e);
    r(5'h0e, 16'h0000);
    cmp("lut", 16'h0004, {13'h0000, linkUpTime});
    w(5'h0d, 16'h0001);
    basicControl = 16'h1140;
    w(5'h0e, 16'h005a);
    w(5'h0d, 16'h4001);
    w(5'h0e, 16'h0006);
    r(5'h0e, 16'h0000);
    cmp("lut", 16'h0004, {13'h0000, linkUpTime});
    r(5'h01, 16'h0000);
    wrap_up;
  end
endmodule
bind imp_portal imp_chk imp_chk_inst (.clk(clk), .rst(rst),
  .regAddr(regAddr), .regWrite(regWrite), .regRead(regRead),
  .regWData(regWData), .basicControl(basicControl), .regHit(regHit),
  .regRData(regRData), .regRValid(regRValid), .linkUpTime(linkUpTime));
